/* File: hw/pfs_debounce.sv */
// debounce or pass-through of one programmable fault condition
`timescale 1ns/1ns
module pfs_debounce #(
	parameter int COUNT = 1
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic raw, // condition from the comparator
	input wire logic immediate, // 1 sets flag at once, 0 after debounce
	output logic flag // qualified fault flag
);
	typedef struct packed {
		logic [pfs_pkg::DEB_WIDTH-1:0] cnt;
		logic flag;
	} pfs_deb_state_t;

	localparam logic [pfs_pkg::DEB_WIDTH-1:0] LAST = pfs_pkg::DEB_WIDTH'(COUNT - 1);

	pfs_deb_state_t s;
	pfs_deb_state_t next_s;

	// flag follows raw once qualified; any drop restarts the count
	always_comb begin
		next_s = s;
		if (!raw) begin
			next_s.cnt = '0;
			next_s.flag = 1'b0;
		end else if (immediate || s.cnt == LAST) begin
			next_s.flag = 1'b1;
		end else begin
			next_s.cnt = s.cnt + pfs_pkg::DEB_WIDTH'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flag = s.flag;

	property p_immediate;
		@(posedge clk) disable iff (!rst_n) (raw && immediate) |=> flag;
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate flag not set");

	property p_drop;
		@(posedge clk) disable iff (!rst_n) (!raw) |=> !flag;
	endproperty
	a_drop: assert property (p_drop) else $error("flag outlived its condition");
endmodule

/* File: hw/pfs_latch8.sv */
// one latched fault register: edge capture, clear on read when gone
`timescale 1ns/1ns
module pfs_latch8 (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic [7:0] live, // live fault bits
	input wire logic clr, // one-cycle read of this register
	output logic [7:0] flag // latched fault bits
);
	typedef struct packed {
		logic [7:0] live_q;
		logic [7:0] flag;
	} pfs_latch_state_t;

	pfs_latch_state_t s;
	pfs_latch_state_t next_s;
	logic [7:0] rise;

	// a new rising edge beats a read clear in the same cycle
	always_comb begin
		next_s = s;
		rise = live & ~s.live_q;
		next_s.live_q = live;
		if (clr) begin
			next_s.flag = (s.flag & live) | rise;
		end else begin
			next_s.flag = s.flag | rise;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= {pfs_pkg::LATCH_RESET, pfs_pkg::LATCH_RESET};
		end else begin
			s <= next_s;
		end
	end

	assign flag = s.flag;

	property p_hold;
		@(posedge clk) disable iff (!rst_n) (!clr) |=> ((flag & $past(flag)) == $past(flag));
	endproperty
	a_hold: assert property (p_hold) else $error("latched flag lost without a read");

	property p_clear_gone;
		@(posedge clk) disable iff (!rst_n) clr |=> ((flag & ~$past(live)) == 8'h00);
	endproperty
	a_clear_gone: assert property (p_clear_gone) else $error("read did not clear");

	property p_keep_present;
		@(posedge clk) disable iff (!rst_n)
			clr |=> ((flag & $past(flag & live)) == $past(flag & live));
	endproperty
	a_keep_present: assert property (p_keep_present) else $error("present fault cleared");

	property p_capture;
		@(posedge clk) disable iff (!rst_n) (|(live & ~s.live_q)) |=> ((flag & $past(rise)) == $past(rise));
	endproperty
	a_capture: assert property (p_capture) else $error("rising edge missed");

	property p_only_edge;
		@(posedge clk) disable iff (!rst_n) 1'b1 |=> ((flag & ~$past(flag) & ~$past(rise)) == 8'h00);
	endproperty
	a_only_edge: assert property (p_only_edge) else $error("held fault set latch");
endmodule

/* File: hw/pfs_pkg.sv */
// shared constants and types for the power fault status block
package pfs_pkg;
	// register offsets on the serial link
	localparam logic [7:0] OFS_LIVE_1 = 8'h00;
	localparam logic [7:0] OFS_LIVE_2 = 8'h01;
	localparam logic [7:0] OFS_LIVE_3 = 8'h02;
	localparam logic [7:0] OFS_LIVE_4 = 8'h03;
	localparam logic [7:0] OFS_LATCH_1 = 8'h04;
	localparam logic [7:0] OFS_LATCH_4 = 8'h07;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

	// live register 1 fields
	localparam int L1_SUPPLY_OFF = 7;
	localparam int L1_ISO_OFF = 6;
	localparam int L1_PG_PRIMARY = 5;
	localparam int L1_PG_EXTENDED = 4;
	localparam int L1_RECT_OFF = 3;
	localparam int L1_FAST_OCP = 2;
	localparam int L1_PRI_OCP = 1;
	localparam int L1_SEC_OCP = 0;
	// live register 2 fields
	localparam int L2_CONTINUITY = 7;
	localparam int L2_UVP = 6;
	localparam int L2_REVERSE = 5;
	localparam int L2_SUPPLY_UV = 4;
	localparam int L2_CORE_OV = 3;
	localparam int L2_SUPPLY_OV = 2;
	localparam int L2_LOAD_OVP = 1;
	localparam int L2_LOCAL_OVP = 0;
	// live register 3 fields (6 and 3 reserved)
	localparam int L3_OTP = 7;
	localparam int L3_SHARE = 5;
	localparam int L3_CONST_CUR = 4;
	localparam int L3_LINE_IMP = 2;
	localparam int L3_SOFT_START = 1;
	localparam int L3_EXT_FLAG = 0;
	// live register 4 fields (7 and 3 reserved)
	localparam int L4_MODULATION = 6;
	localparam int L4_ADDRESS = 5;
	localparam int L4_LIGHT_LOAD = 4;
	localparam int L4_AC_SENSE = 2;
	localparam int L4_CHECKSUM = 1;
	localparam int L4_NVM_UNLOCKED = 0;

	// programmable flags: index into raw, action and timing vectors
	localparam int NUM_PROG = 12;
	localparam int PF_FAST_OCP = 0;
	localparam int PF_PRI_OCP = 1;
	localparam int PF_SEC_OCP = 2;
	localparam int PF_LOAD_OVP = 3;
	localparam int PF_LOCAL_OVP = 4;
	localparam int PF_EXT_FLAG = 5;
	localparam int PF_OTP = 6;
	localparam int PF_UVP = 7;
	localparam int PF_REVERSE = 8;
	localparam int PF_CONTINUITY = 9;
	localparam int PF_SHARE = 10;
	localparam int PF_AC_SENSE = 11;
	localparam int LAST_SHORT_PF = 4;
	localparam int NUM_PG2 = 17;

	// two-bit response codes
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_RECT_OFF = 2'h1;
	localparam logic [1:0] ACT_ISO_OFF = 2'h2;
	localparam logic [1:0] ACT_SHUTDOWN = 2'h3;

	// debounce intervals
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_SHORT_MS = 2;
	localparam int DEBOUNCE_LONG_MS = 100;
	localparam int DEBOUNCE_SHORT_CYC = DEBOUNCE_SHORT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DEBOUNCE_LONG_CYC = DEBOUNCE_LONG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DEB_WIDTH = 24;

	// serial link
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h30;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_WR_BYTE,
		I2C_WR_ACK,
		I2C_RD_BYTE,
		I2C_RD_ACK
	} pfs_i2c_state_t;
endpackage

/* File: hw/pfs_top.sv */
// power fault status block: live and latched fault registers on a serial link
//
// Contract
// - latched flags stay set after fault goes
// - read clears latched flag unless fault present
// - latch sets only on rising fault edge
// - supply-off bit holds until restart
// - isolation-off bit set while gate off
// - primary good fault ORs seven flags
// - extended good fault ORs maskable wider set
// - rectifier-off on user, light load, action
// - fast overcurrent comparator at bit two
// - accurate primary and secondary overcurrent bits
// - continuity fault on sense differentials
// - undervoltage and reverse voltage bits
// - supply undervoltage, core overvoltage shut down
// - supply overvoltage restart needs request toggle
// - load overvoltage separate from local overvoltage
// - register three fault bit placement
// - register three status-only bits
// - register four status bits and reserved
// - ac-sense fault bit
// - checksum shutdown and memory unlocked bits
// - one means fault, zero means normal
// - two-bit response field selects action
// - timing bit selects debounce or immediate
`timescale 1ns/1ns
module pfs_top #(
	parameter int DEBOUNCE_SHORT_CYC = pfs_pkg::DEBOUNCE_SHORT_CYC,
	parameter int DEBOUNCE_LONG_CYC = pfs_pkg::DEBOUNCE_LONG_CYC,
	parameter logic [6:0] DEV_ADDR = pfs_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic ref_clk, // 100 MHz system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic scl_in, // serial clock level
	input wire logic sda_in, // serial data level
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe, // pull serial data low while high
	input wire logic [11:0] prot_cond_raw, // programmable fault conditions
	input wire logic [23:0] prot_action, // two-bit response per flag
	input wire logic [11:0] prot_immediate, // timing bit per flag
	input wire logic supply_undervoltage, // supply below limit
	input wire logic core_rail_overvoltage, // core rail above limit
	input wire logic supply_overvoltage, // supply above limit
	input wire logic checksum_fault, // nonvolatile contents bad
	input wire logic nvm_unlocked, // nonvolatile memory unlocked
	input wire logic constant_current_mode, // constant current operation
	input wire logic line_impedance_high, // remote line impedance high
	input wire logic soft_start_filter_active, // soft-start filter in use
	input wire logic modulation_at_limit, // modulation at min or max
	input wire logic address_resistor_bad, // address resistor wrong
	input wire logic light_load_mode, // load below light-load level
	input wire logic user_rectifier_drive_off, // user disabled both rectifiers
	input wire logic [16:0] power_good_extended_summary_ignore, // per-contributor ignore mask
	input wire logic power_on_request_input, // restart request level
	output logic power_good_primary_summary, // primary good fault, high = fault
	output logic power_good_extended_summary, // extended good fault, high = fault
	output logic rectifiers_disabled_flag, // rectifier drives disabled
	output logic supply_off, // supply shut off
	output logic output_isolation_switch_on // isolation gate enabled
);
	typedef struct packed {
		pfs_pkg::pfs_i2c_state_t st;
		logic scl_q;
		logic sda_q;
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic [7:0] ptr;
		logic ptr_set;
		logic rw;
		logic nack;
		logic sda_oe;
		logic sda_out;
		logic power_on_request_input_q;
		logic supply_off;
		logic iso_on;
		logic rect_off;
		logic pg1;
		logic pg2;
	} pfs_top_state_t;

	logic [1:0] rst_q;
	logic rst_sync_n;
	pfs_top_state_t s;
	pfs_top_state_t next_s;
	logic [11:0] pf;
	logic [7:0] live [4];
	logic [7:0] latched [4];
	logic [3:0] rd_clr;
	logic rd_pulse;
	logic shut_any;
	logic iso_any;
	logic rect_any;
	logic shut_set;
	logic [16:0] pg2_src;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rd_value;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_q[1];

	// overvoltage and overcurrent flags use the short interval
	for (genvar i = 0; i < pfs_pkg::NUM_PROG; i++) begin : g_deb
		pfs_debounce #(
			.COUNT(i <= pfs_pkg::LAST_SHORT_PF ? DEBOUNCE_SHORT_CYC : DEBOUNCE_LONG_CYC)
		) u_deb (
			.clk(ref_clk),
			.rst_n(rst_sync_n),
			.raw(prot_cond_raw[i]),
			.immediate(prot_immediate[i]),
			.flag(pf[i])
		);
	end

	// live register images, high means fault present
	always_comb begin
		live[0] = 8'h00;
		live[1] = 8'h00;
		live[2] = 8'h00;
		live[3] = 8'h00;
		live[0][pfs_pkg::L1_SUPPLY_OFF] = s.supply_off;
		live[0][pfs_pkg::L1_ISO_OFF] = !s.iso_on;
		live[0][pfs_pkg::L1_PG_PRIMARY] = s.pg1;
		live[0][pfs_pkg::L1_PG_EXTENDED] = s.pg2;
		live[0][pfs_pkg::L1_RECT_OFF] = s.rect_off;
		live[0][pfs_pkg::L1_FAST_OCP] = pf[pfs_pkg::PF_FAST_OCP];
		live[0][pfs_pkg::L1_PRI_OCP] = pf[pfs_pkg::PF_PRI_OCP];
		live[0][pfs_pkg::L1_SEC_OCP] = pf[pfs_pkg::PF_SEC_OCP];
		live[1][pfs_pkg::L2_CONTINUITY] = pf[pfs_pkg::PF_CONTINUITY];
		live[1][pfs_pkg::L2_UVP] = pf[pfs_pkg::PF_UVP];
		live[1][pfs_pkg::L2_REVERSE] = pf[pfs_pkg::PF_REVERSE];
		live[1][pfs_pkg::L2_SUPPLY_UV] = supply_undervoltage;
		live[1][pfs_pkg::L2_CORE_OV] = core_rail_overvoltage;
		live[1][pfs_pkg::L2_SUPPLY_OV] = supply_overvoltage;
		live[1][pfs_pkg::L2_LOAD_OVP] = pf[pfs_pkg::PF_LOAD_OVP];
		live[1][pfs_pkg::L2_LOCAL_OVP] = pf[pfs_pkg::PF_LOCAL_OVP];
		live[2][pfs_pkg::L3_OTP] = pf[pfs_pkg::PF_OTP];
		live[2][pfs_pkg::L3_SHARE] = pf[pfs_pkg::PF_SHARE];
		live[2][pfs_pkg::L3_EXT_FLAG] = pf[pfs_pkg::PF_EXT_FLAG];
		live[2][pfs_pkg::L3_CONST_CUR] = constant_current_mode;
		live[2][pfs_pkg::L3_LINE_IMP] = line_impedance_high;
		live[2][pfs_pkg::L3_SOFT_START] = soft_start_filter_active;
		live[3][pfs_pkg::L4_MODULATION] = modulation_at_limit;
		live[3][pfs_pkg::L4_ADDRESS] = address_resistor_bad;
		live[3][pfs_pkg::L4_LIGHT_LOAD] = light_load_mode;
		live[3][pfs_pkg::L4_AC_SENSE] = pf[pfs_pkg::PF_AC_SENSE];
		live[3][pfs_pkg::L4_CHECKSUM] = checksum_fault;
		live[3][pfs_pkg::L4_NVM_UNLOCKED] = nvm_unlocked;
	end

	// one latched copy per live register, all the same structure
	for (genvar r = 0; r < 4; r++) begin : g_latch
		pfs_latch8 u_latch (
			.clk(ref_clk),
			.rst_n(rst_sync_n),
			.live(live[r]),
			.clr(rd_clr[r]),
			.flag(latched[r])
		);
	end

	// response decode of every qualified programmable flag
	always_comb begin
		shut_any = 1'b0;
		iso_any = 1'b0;
		rect_any = 1'b0;
		for (int i = 0; i < pfs_pkg::NUM_PROG; i++) begin
			case (prot_action[2*i +: 2])
				pfs_pkg::ACT_RECT_OFF: rect_any = rect_any | pf[i];
				pfs_pkg::ACT_ISO_OFF: iso_any = iso_any | pf[i];
				pfs_pkg::ACT_SHUTDOWN: shut_any = shut_any | pf[i];
				default: ;
			endcase
		end
	end

	// hard faults shut down with no programmable response
	assign shut_set = shut_any | supply_undervoltage | core_rail_overvoltage
		| supply_overvoltage | checksum_fault;

	// extended summary contributors, each one maskable
	assign pg2_src = {s.supply_off, !s.iso_on, pf[pfs_pkg::PF_FAST_OCP],
		pf[pfs_pkg::PF_PRI_OCP], pf[pfs_pkg::PF_SEC_OCP], pf[pfs_pkg::PF_CONTINUITY],
		pf[pfs_pkg::PF_UVP], pf[pfs_pkg::PF_REVERSE], pf[pfs_pkg::PF_AC_SENSE],
		pf[pfs_pkg::PF_EXT_FLAG], core_rail_overvoltage, supply_overvoltage,
		pf[pfs_pkg::PF_LOCAL_OVP], pf[pfs_pkg::PF_LOAD_OVP], pf[pfs_pkg::PF_OTP],
		checksum_fault, nvm_unlocked};

	// register read value; anything above the latched block reads zero
	always_comb begin
		if (s.ptr < pfs_pkg::OFS_LATCH_1) begin
			rd_value = live[s.ptr[1:0]];
		end else if (s.ptr <= pfs_pkg::OFS_LATCH_4) begin
			rd_value = latched[s.ptr[1:0]];
		end else begin
			rd_value = pfs_pkg::UNMAPPED_VALUE;
		end
	end

	assign scl_rise = !s.scl_q && scl_in;
	assign scl_fall = s.scl_q && !scl_in;
	assign start_cond = s.scl_q && scl_in && s.sda_q && !sda_in;
	assign stop_cond = s.scl_q && scl_in && !s.sda_q && sda_in;

	// serial slave plus supply state; only latched offsets clear on load
	always_comb begin
		next_s = s;
		rd_pulse = 1'b0;
		next_s.scl_q = scl_in;
		next_s.sda_q = sda_in;
		next_s.power_on_request_input_q = power_on_request_input;
		next_s.sda_out = 1'b0;
		// restart needs a fresh request edge and no cause left
		if (shut_set) begin
			next_s.supply_off = 1'b1;
		end else if (power_on_request_input && !s.power_on_request_input_q) begin
			next_s.supply_off = 1'b0;
		end
		next_s.iso_on = !(next_s.supply_off || iso_any);
		next_s.rect_off = user_rectifier_drive_off || light_load_mode || rect_any;
		next_s.pg1 = s.supply_off || pf[pfs_pkg::PF_FAST_OCP] || pf[pfs_pkg::PF_PRI_OCP]
			|| pf[pfs_pkg::PF_SEC_OCP] || pf[pfs_pkg::PF_UVP]
			|| pf[pfs_pkg::PF_LOCAL_OVP] || pf[pfs_pkg::PF_LOAD_OVP];
		next_s.pg2 = |(pg2_src & ~power_good_extended_summary_ignore);
		if (start_cond) begin
			next_s.st = pfs_pkg::I2C_ADDR;
			next_s.cnt = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.ptr_set = 1'b0;
		end else if (stop_cond) begin
			next_s.st = pfs_pkg::I2C_IDLE;
			next_s.sda_oe = 1'b0;
		end else begin
			case (s.st)
				pfs_pkg::I2C_IDLE: begin
					next_s.sda_oe = 1'b0;
				end
				pfs_pkg::I2C_ADDR: begin
					if (scl_rise) begin
						next_s.shreg = {s.shreg[6:0], sda_in};
						next_s.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == pfs_pkg::BITS_PER_BYTE) begin
						if (s.shreg[7:1] == DEV_ADDR) begin
							next_s.rw = s.shreg[0];
							next_s.sda_oe = 1'b1;
							next_s.st = pfs_pkg::I2C_ADDR_ACK;
						end else begin
							next_s.st = pfs_pkg::I2C_IDLE;
						end
					end
				end
				pfs_pkg::I2C_ADDR_ACK: begin
					if (scl_fall) begin
						next_s.cnt = 4'h0;
						if (s.rw) begin
							rd_pulse = 1'b1;
							next_s.shreg = rd_value;
							next_s.sda_oe = !rd_value[7];
							next_s.ptr = s.ptr + 8'h01;
							next_s.st = pfs_pkg::I2C_RD_BYTE;
						end else begin
							next_s.sda_oe = 1'b0;
							next_s.st = pfs_pkg::I2C_WR_BYTE;
						end
					end
				end
				pfs_pkg::I2C_WR_BYTE: begin
					if (scl_rise) begin
						next_s.shreg = {s.shreg[6:0], sda_in};
						next_s.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == pfs_pkg::BITS_PER_BYTE) begin
						// first byte is the pointer; later writes are acked, dropped
						if (!s.ptr_set) begin
							next_s.ptr = s.shreg;
							next_s.ptr_set = 1'b1;
						end
						next_s.sda_oe = 1'b1;
						next_s.st = pfs_pkg::I2C_WR_ACK;
					end
				end
				pfs_pkg::I2C_WR_ACK: begin
					if (scl_fall) begin
						next_s.sda_oe = 1'b0;
						next_s.cnt = 4'h0;
						next_s.st = pfs_pkg::I2C_WR_BYTE;
					end
				end
				pfs_pkg::I2C_RD_BYTE: begin
					if (scl_fall) begin
						if (s.cnt == pfs_pkg::LAST_TX_BIT) begin
							next_s.sda_oe = 1'b0;
							next_s.st = pfs_pkg::I2C_RD_ACK;
						end else begin
							next_s.shreg = {s.shreg[6:0], 1'b0};
							next_s.sda_oe = !s.shreg[6];
							next_s.cnt = s.cnt + 4'h1;
						end
					end
				end
				pfs_pkg::I2C_RD_ACK: begin
					if (scl_rise) begin
						next_s.nack = sda_in;
					end else if (scl_fall) begin
						next_s.cnt = 4'h0;
						if (s.nack) begin
							next_s.st = pfs_pkg::I2C_IDLE;
						end else begin
							rd_pulse = 1'b1;
							next_s.shreg = rd_value;
							next_s.sda_oe = !rd_value[7];
							next_s.ptr = s.ptr + 8'h01;
							next_s.st = pfs_pkg::I2C_RD_BYTE;
						end
					end
				end
				default: begin
					next_s.st = pfs_pkg::I2C_IDLE;
					next_s.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// clear strobe only for the latched block; live reads leave flags alone
	always_comb begin
		rd_clr = 4'h0;
		if (rd_pulse && s.ptr >= pfs_pkg::OFS_LATCH_1 && s.ptr <= pfs_pkg::OFS_LATCH_4) begin
			rd_clr[s.ptr[1:0]] = 1'b1;
		end
	end

	// idle bus lines rest high; supply starts off until requested
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s <= '0;
			s.st <= pfs_pkg::I2C_IDLE;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.supply_off <= 1'b1;
			s.pg1 <= 1'b1;
			s.pg2 <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign sda_out = s.sda_out;
	assign sda_oe = s.sda_oe;
	assign supply_off = s.supply_off;
	assign output_isolation_switch_on = s.iso_on;
	assign rectifiers_disabled_flag = s.rect_off;
	assign power_good_primary_summary = s.pg1;
	assign power_good_extended_summary = s.pg2;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_shutdown_cause;
		supply_undervoltage || core_rail_overvoltage;
	endsequence

	property p_hard_shutdown;
		s_shutdown_cause |=> supply_off;
	endproperty
	a_hard_shutdown: assert property (p_hard_shutdown) else $error("no shutdown");

	property p_off_holds;
		(supply_off && !(power_on_request_input && !s.power_on_request_input_q)) |=> supply_off;
	endproperty
	a_off_holds: assert property (p_off_holds) else $error("supply off dropped early");

	property p_ov_restart;
		(supply_overvoltage && supply_off) |=> supply_off;
	endproperty
	a_ov_restart: assert property (p_ov_restart) else $error("restart during overvoltage");

	property p_iso_off;
		supply_off |-> (!output_isolation_switch_on && live[0][pfs_pkg::L1_ISO_OFF]);
	endproperty
	a_iso_off: assert property (p_iso_off) else $error("gate on while off");

	property p_pg1;
		(pf[pfs_pkg::PF_FAST_OCP] || pf[pfs_pkg::PF_UVP]) |=> power_good_primary_summary;
	endproperty
	a_pg1: assert property (p_pg1) else $error("primary good fault missing");

	property p_pg2_mask;
		(power_good_extended_summary_ignore == 17'h1ffff) |=> !power_good_extended_summary;
	endproperty
	a_pg2_mask: assert property (p_pg2_mask) else $error("ignored flag reached summary");

	property p_rect;
		(user_rectifier_drive_off || light_load_mode) |=> rectifiers_disabled_flag;
	endproperty
	a_rect: assert property (p_rect) else $error("rectifiers not flagged off");

	property p_action_shut;
		(pf[pfs_pkg::PF_FAST_OCP] && prot_action[1:0] == pfs_pkg::ACT_SHUTDOWN) |=> supply_off;
	endproperty
	a_action_shut: assert property (p_action_shut) else $error("shutdown action ignored");

	property p_live_no_clear;
		(rd_pulse && s.ptr < pfs_pkg::OFS_LATCH_1) |-> (rd_clr == 4'h0);
	endproperty
	a_live_no_clear: assert property (p_live_no_clear) else $error("live read cleared a latch");
endmodule

/* File: verif/pfs_host.sv */
// serial host model that reads the fault registers
`timescale 1ns/1ns
module pfs_host (
	input wire logic clk, // system clock
	input wire logic sda_oe, // device pulls data low
	output logic scl, // serial clock
	output logic sda // wire level, pulled up
);
	logic drv = 1'b1;
	int ph = 4; // clocks per phase, three phases per bit, raise it to act slow
	initial scl = 1'b1;
	// open drain: a released wire floats high
	assign sda = drv & ~sda_oe;
	task automatic hp;
		repeat (ph) @(posedge clk);
		#1;
	endtask
	// data moves only while the clock is low
	task automatic bitc(input logic b, output logic s);
		drv = b;
		hp();
		scl = 1'b1;
		hp();
		s = sda;
		scl = 1'b0;
		hp();
	endtask
	task automatic xfer(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--)
			bitc(o[k], i[k]);
	endtask
	task automatic start;
		drv = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		drv = 1'b0;
		hp();
		scl = 1'b0;
		hp();
	endtask
	// pointer write, repeated start, one byte read with a closing nack
	task automatic rd(input logic [7:0] p, input logic [6:0] a, output logic [7:0] d,
		output logic ok);
		logic [8:0] i1, i2, i3, i4;
		start();
		xfer({a, 2'b01}, i1);
		xfer({p, 1'b1}, i2);
		start();
		xfer({a, 2'b11}, i3);
		xfer(9'h1ff, i4);
		drv = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		drv = 1'b1;
		hp();
		d = i4[8:1];
		ok = ~(i1[0] | i2[0] | i3[0]);
	endtask
endmodule

/* File: verif/power_fault_status_registers_tb.sv */
// self-checking bench for the power fault status block
`timescale 1ns/1ns
module power_fault_status_registers_tb;
	logic ref_clk = 1'b0, rst_n = 1'b0, scl, sda, sda_out, sda_oe, pon = 1'b0, uoff = 1'b0;
	logic [11:0] raw = '0, imm = '1;
	logic [23:0] act = '0;
	logic [10:0] st = '0;
	logic [16:0] ign = '0;
	logic pg1, pg2, rect, soff, iso, ok;
	logic [7:0] d;
	int num_errors = 0, samples_checked = 0;
	initial forever #5 ref_clk = ~ref_clk;
	pfs_host host (.clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	pfs_top #(.DEBOUNCE_SHORT_CYC(8), .DEBOUNCE_LONG_CYC(20)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.prot_cond_raw(raw), .prot_action(act), .prot_immediate(imm),
		.supply_undervoltage(st[10]), .core_rail_overvoltage(st[9]),
		.supply_overvoltage(st[8]), .checksum_fault(st[7]), .nvm_unlocked(st[6]),
		.constant_current_mode(st[5]), .line_impedance_high(st[4]),
		.soft_start_filter_active(st[3]), .modulation_at_limit(st[2]),
		.address_resistor_bad(st[1]), .light_load_mode(st[0]),
		.user_rectifier_drive_off(uoff), .power_good_extended_summary_ignore(ign), .power_on_request_input(pon),
		.power_good_primary_summary(pg1), .power_good_extended_summary(pg2),
		.rectifiers_disabled_flag(rect), .supply_off(soff), .output_isolation_switch_on(iso));
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g,
		input logic [7:0] m);
		samples_checked++;
		if ((g & m) !== (e & m)) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e & m, g & m);
		end
	endtask
	task automatic port(input string n, input logic e, input logic g);
		chk(n, {7'h0, e}, {7'h0, g}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e, input logic [7:0] m);
		host.rd(p, pfs_pkg::DEV_ADDR_DEFAULT, d, ok);
		port("ack", 1'b1, ok);
		port("sda_out", 1'b0, sda_out);
		chk($sformatf("reg %h", p), e, d, m);
	endtask
	task automatic restart;
		pon = 1'b1;
		cyc(4);
		pon = 1'b0;
		cyc(4);
	endtask
	// capture, hold while present, clear only once gone
	task automatic s_latch;
		restart();
		rd(8'h04, 8'hf0, 8'hff);
		rd(8'h04, 8'h00, 8'hff);
		raw[2] = 1'b1;
		cyc(3);
		rd(8'h00, 8'h31, 8'h31);
		rd(8'h04, 8'h31, 8'h31);
		rd(8'h04, 8'h31, 8'h31);
		raw[2] = 1'b0;
		cyc(3);
		rd(8'h00, 8'h00, 8'h31);
		rd(8'h04, 8'h31, 8'h31);
		rd(8'h04, 8'h00, 8'h31);
	endtask
	// fault bits of registers two to four placed, reserved bits low, shutdown held until restart
	task automatic s_map;
		raw = 12'hff8;
		st = '1;
		cyc(3);
		rd(8'h01, 8'hff, 8'hff);
		rd(8'h02, 8'hb7, 8'hff);
		rd(8'h03, 8'h77, 8'hff);
		port("rect", 1'b1, rect);
		raw = '0;
		st = '0;
		cyc(4);
		port("soff", 1'b1, soff);
		restart();
		port("soff", 1'b0, soff);
	endtask
	// each response code in turn on the fast overcurrent flag
	task automatic s_act;
		for (int a = 0; a < 4; a++) begin
			act[1:0] = 2'(a);
			raw[0] = 1'b1;
			cyc(3);
			port("rect", a == 1, rect);
			port("iso", a < 2, iso);
			rd(8'h00, {a == 3, a > 1, 2'h0, a == 1, 3'h4}, 8'hcc);
			raw[0] = 1'b0;
			cyc(3);
		end
		act = '0;
		restart();
		uoff = 1'b1;
		cyc(3);
		port("rect", 1'b1, rect);
		uoff = 1'b0;
	endtask
	// ignore mask, then the debounce interval
	task automatic s_sum;
		ign = 17'h1f000;
		raw[2] = 1'b1;
		cyc(3);
		port("pg2", 1'b0, pg2);
		port("pg1", 1'b1, pg1);
		ign = '1;
		cyc(2);
		port("pg2", 1'b0, pg2);
		ign = '0;
		cyc(3);
		port("pg2", 1'b1, pg2);
		raw[2] = 1'b0;
		imm[1] = 1'b0;
		cyc(3);
		raw[1] = 1'b1;
		cyc(5);
		port("pg1", 1'b0, pg1);
		cyc(6);
		port("pg1", 1'b1, pg1);
	endtask
	// slow host on an unmapped pointer, then a wrong address
	task automatic s_bus;
		host.ph = 9;
		rd(8'h09, 8'h00, 8'hff);
		host.ph = 4;
		host.rd(8'h00, 7'h31, d, ok);
		port("nack", 1'b0, ok);
	endtask
	task automatic results;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		s_latch();
		s_map();
		s_act();
		s_sum();
		s_bus();
		results();
	end
	// a hang counts as a mismatch
	initial begin
		#500000;
		num_errors++;
		results();
	end
endmodule
